// >>> hdl/cem_pkg.sv
package cem_pkg;

  // ----------------------------------------------------------------
  // special register selects
  // ----------------------------------------------------------------
  localparam logic [2:0] SEL_PRI = 3'h0;
  localparam logic [2:0] SEL_ESC = 3'h1;
  localparam logic [2:0] SEL_FLOOR = 3'h2;
  localparam logic [2:0] SEL_CTRL = 3'h3;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int FLOOR_LSB = 4;
  localparam int FLOOR_W = 4;
  localparam int CTRL_THREAD_PRIVILEGE_BIT = 0;
  localparam int CTRL_ACTIVE_STACK_SELECT = 1;
  localparam int XS_T_BIT = 24;
  localparam int XS_HI_LSB = 25;
  localparam int XS_LO_LSB = 10;
  localparam int XS_IDX_LSB = 12;
  localparam int RET_THREAD_BIT = 3;
  localparam int RET_PSP_BIT = 2;

  // ----------------------------------------------------------------
  // reset values and counts
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [7:0] RST_COND = 8'h00;
  localparam int COND_BLOCK_MAX = 4;

  // ----------------------------------------------------------------
  // execution state modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    XS_NONE,
    XS_SUSPEND,
    XS_COND
  } cem_xs_mode_t;

endpackage : cem_pkg

// >>> hdl/cem_mask_gate.sv
`timescale 1ns/1ps
module cem_mask_gate (
  input wire logic pri_i,
  input wire logic esc_i,
  input wire logic [3:0] floor_i,
  input wire logic req_valid_i,
  input wire logic req_cfg_i,
  input wire logic req_nmi_i,
  input wire logic [7:0] req_prio_i,
  output logic allow_o
);

  // ----------------------------------------------------------------
  // mask combination
  // ----------------------------------------------------------------
  logic [7:0] floor_val;
  logic pri_hit;
  logic esc_hit;
  logic floor_hit;

  always_comb begin
    floor_val = {floor_i, 4'h0};
    pri_hit = pri_i && req_cfg_i;
    esc_hit = esc_i && !req_nmi_i;
    floor_hit = (floor_i != 4'h0) && req_cfg_i &&
      (req_prio_i >= floor_val);
    allow_o = req_valid_i && !pri_hit && !esc_hit && !floor_hit;
  end

endmodule : cem_mask_gate

// >>> hdl/cem_exec_state.sv
`timescale 1ns/1ps
module cem_exec_state (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic mr_suspend_i,
  input wire logic [3:0] mr_next_idx_i,
  input wire logic mr_resume_i,
  input wire logic cb_load_i,
  input wire logic [7:0] cb_state_i,
  input wire logic cb_advance_i,
  input wire logic br_wr_i,
  input wire logic br_bit0_i,
  input wire logic vec_fetch_i,
  input wire logic vec_bit0_i,
  input wire logic stk_restore_i,
  input wire logic [31:0] stk_xs_i,
  input wire logic exec_try_i,
  output logic [31:0] xs_o,
  output logic resume_valid_o,
  output logic [3:0] resume_idx_o,
  output logic cb_active_o,
  output logic t_fault_o
);

  localparam int XS_LO_LSB_P = cem_pkg::XS_LO_LSB;
  localparam int XS_HI_LSB_P = cem_pkg::XS_HI_LSB;
  localparam int XS_T_BIT_P = cem_pkg::XS_T_BIT;

  typedef struct packed {
    logic t;
    cem_pkg::cem_xs_mode_t mode;
    logic [7:0] bits;
    logic resume_valid;
    logic [3:0] resume_idx;
    logic t_fault;
    logic cb_active;
  } cem_xs_t;

  cem_xs_t st_ff;
  cem_xs_t nxt_st;
  logic [7:0] rs_bits;
  logic [3:0] rs_zero;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.resume_valid = 1'b0;
    nxt_st.t_fault = exec_try_i && !st_ff.t;
    rs_bits = {stk_xs_i[XS_LO_LSB_P+5:XS_LO_LSB_P],
      stk_xs_i[XS_HI_LSB_P+1:XS_HI_LSB_P]};
    rs_zero = {stk_xs_i[XS_HI_LSB_P+1:XS_HI_LSB_P],
      stk_xs_i[XS_LO_LSB_P+1:XS_LO_LSB_P]};
    if (st_ff.mode == cem_pkg::XS_COND && cb_advance_i) begin
      if (st_ff.bits[2:0] == 3'h0) begin
        nxt_st.mode = cem_pkg::XS_NONE;
        nxt_st.bits = cem_pkg::RST_COND;
      end else begin
        nxt_st.bits = {st_ff.bits[7:5], st_ff.bits[3:0], 1'b0};
      end
    end
    if (cb_load_i) begin
      nxt_st.mode = cem_pkg::XS_COND;
      nxt_st.bits = cb_state_i;
    end
    if (mr_resume_i && st_ff.mode == cem_pkg::XS_SUSPEND) begin
      nxt_st.resume_valid = 1'b1;
      nxt_st.resume_idx = st_ff.bits[7:4];
      nxt_st.mode = cem_pkg::XS_NONE;
      nxt_st.bits = cem_pkg::RST_COND;
    end
    if (mr_suspend_i) begin
      nxt_st.mode = cem_pkg::XS_SUSPEND;
      nxt_st.bits = {mr_next_idx_i, 4'h0};
    end
    if (br_wr_i) begin
      nxt_st.t = br_bit0_i;
    end
    if (stk_restore_i) begin
      nxt_st.t = stk_xs_i[XS_T_BIT_P];
      if (rs_zero == 4'h0 && rs_bits[7:4] != 4'h0) begin
        nxt_st.mode = cem_pkg::XS_SUSPEND;
        nxt_st.bits = {rs_bits[7:4], 4'h0};
      end else if (rs_bits != 8'h00) begin
        nxt_st.mode = cem_pkg::XS_COND;
        nxt_st.bits = rs_bits;
      end else begin
        nxt_st.mode = cem_pkg::XS_NONE;
        nxt_st.bits = cem_pkg::RST_COND;
      end
    end
    if (vec_fetch_i) begin
      nxt_st.t = vec_bit0_i;
    end
    nxt_st.cb_active = (nxt_st.mode == cem_pkg::XS_COND);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_comb begin
    xs_o = cem_pkg::RST_WORD;
    xs_o[XS_T_BIT_P] = st_ff.t;
    xs_o[XS_HI_LSB_P+1:XS_HI_LSB_P] = st_ff.bits[1:0];
    xs_o[XS_LO_LSB_P+5:XS_LO_LSB_P] = st_ff.bits[7:2];
  end
  assign resume_valid_o = st_ff.resume_valid;
  assign resume_idx_o = st_ff.resume_idx;
  assign cb_active_o = st_ff.cb_active;
  assign t_fault_o = st_ff.t_fault;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_suspend;
    mr_suspend_i && !stk_restore_i;
  endsequence

  sequence s_resume;
    mr_resume_i && !mr_suspend_i && !stk_restore_i;
  endsequence

  a_suspend_index: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    s_suspend |=> xs_o[15:12] == $past(mr_next_idx_i))
    else $error("suspend index not saved");

  a_suspend_zero: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    st_ff.mode == cem_pkg::XS_SUSPEND |->
      xs_o[26:25] == 2'h0 && xs_o[11:10] == 2'h0)
    else $error("continuation bits not zero");

  a_resume_index: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    s_suspend ##1 s_resume |=>
      resume_valid_o && resume_idx_o == $past(mr_next_idx_i, 2))
    else $error("resume index wrong");

  a_tbit_fault: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    exec_try_i && !xs_o[24] |=> t_fault_o)
    else $error("no fault with instruction state clear");

  a_branch_tbit: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    br_wr_i && !br_bit0_i && !vec_fetch_i && !stk_restore_i |=> !xs_o[24])
    else $error("instruction state bit not cleared");

endmodule : cem_exec_state

// >>> hdl/cem_core_mask_ctrl.sv
`timescale 1ns/1ps
module cem_core_mask_ctrl (
  input wire logic CLK_SYS_I,
  input wire logic RESETN_I,
  input wire logic SR_WR_I,
  input wire logic SR_RD_I,
  input wire logic [2:0] SR_SEL_I,
  input wire logic [31:0] SR_WDATA_I,
  input wire logic CPS_I,
  input wire logic CPS_SET_I,
  input wire logic CPS_PRI_I,
  input wire logic CPS_ESC_I,
  input wire logic EXC_ENTRY_I,
  input wire logic EXCEPTION_RETURN_CODE_I,
  input wire logic [3:0] EXC_RET_CODE_I,
  input wire logic EXC_RET_NMI_I,
  input wire logic EXC_REQ_VALID_I,
  input wire logic EXC_REQ_CFG_I,
  input wire logic EXC_REQ_NMI_I,
  input wire logic [7:0] EXC_REQ_PRIO_I,
  input wire logic MR_SUSPEND_I,
  input wire logic [3:0] MR_NEXT_IDX_I,
  input wire logic MR_RESUME_I,
  input wire logic CB_LOAD_I,
  input wire logic [7:0] CB_STATE_I,
  input wire logic CB_ADVANCE_I,
  input wire logic BR_WR_I,
  input wire logic BR_BIT0_I,
  input wire logic VEC_FETCH_I,
  input wire logic VEC_BIT0_I,
  input wire logic STK_RESTORE_I,
  input wire logic [31:0] STK_XS_I,
  input wire logic EXEC_TRY_I,
  output logic [31:0] SR_RDATA_O,
  output logic PRI_BLOCK_O,
  output logic ESC_BLOCK_O,
  output logic [7:0] FLOOR_O,
  output logic USE_PSP_O,
  output logic UNPRIV_O,
  output logic HANDLER_MODE_O,
  output logic EXC_ALLOW_O,
  output logic [31:0] XS_O,
  output logic RESUME_VALID_O,
  output logic [3:0] RESUME_IDX_O,
  output logic CB_ACTIVE_O,
  output logic T_FAULT_O
);

  localparam int FL_LSB = cem_pkg::FLOOR_LSB;
  localparam int FL_MSB = cem_pkg::FLOOR_LSB + cem_pkg::FLOOR_W - 1;

  typedef struct packed {
    logic pri;
    logic esc;
    logic [3:0] floor_val;
    logic active_stack_select;
    logic thread_privilege_bit;
    logic handler;
    logic [31:0] rdata;
    logic allow;
  } cem_regs_t;

  cem_regs_t st_ff;
  cem_regs_t nxt_st;
  logic allow_c;

  // ----------------------------------------------------------------
  // select decode
  // ----------------------------------------------------------------
  function automatic logic sel_hit(input logic [2:0] sel,
                                   input logic [2:0] code);
    sel_hit = (sel == code);
  endfunction : sel_hit

  function automatic logic [31:0] rd_word(input logic [2:0] sel,
                                          input cem_regs_t s);
    logic [31:0] w;
    w = cem_pkg::RST_WORD;
    if (sel_hit(sel, cem_pkg::SEL_PRI)) begin
      w[0] = s.pri;
    end
    if (sel_hit(sel, cem_pkg::SEL_ESC)) begin
      w[0] = s.esc;
    end
    if (sel_hit(sel, cem_pkg::SEL_FLOOR)) begin
      w[FL_MSB:FL_LSB] = s.floor_val;
    end
    if (sel_hit(sel, cem_pkg::SEL_CTRL)) begin
      w[cem_pkg::CTRL_THREAD_PRIVILEGE_BIT] = s.thread_privilege_bit;
      w[cem_pkg::CTRL_ACTIVE_STACK_SELECT] = s.active_stack_select && !s.handler;
    end
    rd_word = w;
  endfunction : rd_word

  // ----------------------------------------------------------------
  // sub blocks
  // ----------------------------------------------------------------
  cem_mask_gate u_gate (
    .pri_i(st_ff.pri),
    .esc_i(st_ff.esc),
    .floor_i(st_ff.floor_val),
    .req_valid_i(EXC_REQ_VALID_I),
    .req_cfg_i(EXC_REQ_CFG_I),
    .req_nmi_i(EXC_REQ_NMI_I),
    .req_prio_i(EXC_REQ_PRIO_I),
    .allow_o(allow_c)
  );

  cem_exec_state u_xs (
    .clk_i(CLK_SYS_I),
    .rst_n_i(RESETN_I),
    .mr_suspend_i(MR_SUSPEND_I),
    .mr_next_idx_i(MR_NEXT_IDX_I),
    .mr_resume_i(MR_RESUME_I),
    .cb_load_i(CB_LOAD_I),
    .cb_state_i(CB_STATE_I),
    .cb_advance_i(CB_ADVANCE_I),
    .br_wr_i(BR_WR_I),
    .br_bit0_i(BR_BIT0_I),
    .vec_fetch_i(VEC_FETCH_I),
    .vec_bit0_i(VEC_BIT0_I),
    .stk_restore_i(STK_RESTORE_I),
    .stk_xs_i(STK_XS_I),
    .exec_try_i(EXEC_TRY_I),
    .xs_o(XS_O),
    .resume_valid_o(RESUME_VALID_O),
    .resume_idx_o(RESUME_IDX_O),
    .cb_active_o(CB_ACTIVE_O),
    .t_fault_o(T_FAULT_O)
  );

  // ----------------------------------------------------------------
  // register next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.allow = allow_c;
    if (SR_RD_I) begin
      nxt_st.rdata = rd_word(SR_SEL_I, st_ff);
    end
    if (EXCEPTION_RETURN_CODE_I && !EXC_RET_NMI_I) begin
      nxt_st.esc = 1'b0;
    end
    if (EXCEPTION_RETURN_CODE_I) begin
      if (EXC_RET_CODE_I[cem_pkg::RET_THREAD_BIT]) begin
        nxt_st.handler = 1'b0;
        nxt_st.active_stack_select = EXC_RET_CODE_I[cem_pkg::RET_PSP_BIT];
      end else begin
        nxt_st.handler = 1'b1;
        nxt_st.active_stack_select = 1'b0;
      end
    end
    if (EXC_ENTRY_I) begin
      nxt_st.handler = 1'b1;
      nxt_st.active_stack_select = 1'b0;
    end
    if (SR_WR_I && sel_hit(SR_SEL_I, cem_pkg::SEL_PRI)) begin
      nxt_st.pri = SR_WDATA_I[0];
    end
    if (SR_WR_I && sel_hit(SR_SEL_I, cem_pkg::SEL_ESC)) begin
      nxt_st.esc = SR_WDATA_I[0];
    end
    if (SR_WR_I && sel_hit(SR_SEL_I, cem_pkg::SEL_FLOOR)) begin
      nxt_st.floor_val = SR_WDATA_I[FL_MSB:FL_LSB];
    end
    if (SR_WR_I && sel_hit(SR_SEL_I, cem_pkg::SEL_CTRL)) begin
      nxt_st.thread_privilege_bit = SR_WDATA_I[cem_pkg::CTRL_THREAD_PRIVILEGE_BIT];
      if (!st_ff.handler && !EXC_ENTRY_I) begin
        nxt_st.active_stack_select = SR_WDATA_I[cem_pkg::CTRL_ACTIVE_STACK_SELECT];
      end
    end
    if (CPS_I && CPS_PRI_I) begin
      nxt_st.pri = CPS_SET_I;
    end
    if (CPS_I && CPS_ESC_I) begin
      nxt_st.esc = CPS_SET_I;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign SR_RDATA_O = st_ff.rdata;
  assign PRI_BLOCK_O = st_ff.pri;
  assign ESC_BLOCK_O = st_ff.esc;
  assign FLOOR_O = {st_ff.floor_val, 4'h0};
  assign USE_PSP_O = st_ff.active_stack_select;
  assign UNPRIV_O = st_ff.thread_privilege_bit;
  assign HANDLER_MODE_O = st_ff.handler;
  assign EXC_ALLOW_O = st_ff.allow;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb_chk @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!RESETN_I);

  logic ctrl_wr;
  logic esc_set;
  assign ctrl_wr = SR_WR_I && SR_SEL_I == cem_pkg::SEL_CTRL;
  assign esc_set = (SR_WR_I && SR_SEL_I == cem_pkg::SEL_ESC) ||
    (CPS_I && CPS_ESC_I);

  a_pri_blocks: assert property (
    PRI_BLOCK_O && EXC_REQ_CFG_I |=> !EXC_ALLOW_O)
    else $error("configurable exception not blocked");

  a_esc_blocks: assert property (
    ESC_BLOCK_O && !EXC_REQ_NMI_I |=> !EXC_ALLOW_O)
    else $error("non nmi exception not blocked");

  a_esc_exit_clear: assert property (
    EXCEPTION_RETURN_CODE_I && !EXC_RET_NMI_I && !esc_set |=> !ESC_BLOCK_O)
    else $error("escalated block not cleared on exit");

  a_floor_blocks: assert property (
    FLOOR_O != 8'h00 && EXC_REQ_CFG_I && EXC_REQ_PRIO_I >= FLOOR_O
      |=> !EXC_ALLOW_O)
    else $error("floor did not block exception");

  a_floor_low_zero: assert property (
    SR_RD_I && SR_SEL_I == cem_pkg::SEL_FLOOR |=>
      SR_RDATA_O[3:0] == 4'h0 && SR_RDATA_O[7:4] == $past(FLOOR_O[7:4]))
    else $error("floor low nibble not zero");

  a_handler_main: assert property (
    HANDLER_MODE_O && ctrl_wr && !EXCEPTION_RETURN_CODE_I |=> !USE_PSP_O [*2])
    else $error("handler mode left main stack");

  a_thread_psp: assert property (
    EXCEPTION_RETURN_CODE_I && !EXC_ENTRY_I && EXC_RET_CODE_I == 4'hD |=>
      USE_PSP_O && !HANDLER_MODE_O)
    else $error("return code did not select process stack");

  a_entry_handler: assert property (
    EXC_ENTRY_I |=> HANDLER_MODE_O && !USE_PSP_O)
    else $error("entry did not enter handler mode");

  a_priv_write: assert property (
    ctrl_wr |=> UNPRIV_O == $past(SR_WDATA_I[0]))
    else $error("privilege bit not written");

  a_all_clear: assert property (
    EXC_REQ_VALID_I && !PRI_BLOCK_O && !ESC_BLOCK_O && FLOOR_O == 8'h00
      |=> EXC_ALLOW_O)
    else $error("unmasked exception not allowed");

  a_cps_pri_set: assert property (
    CPS_I && CPS_PRI_I |=> PRI_BLOCK_O == $past(CPS_SET_I))
    else $error("state change did not load block bit");

  a_floor_write: assert property (
    SR_WR_I && SR_SEL_I == cem_pkg::SEL_FLOOR |=>
      FLOOR_O[7:4] == $past(SR_WDATA_I[7:4]) && FLOOR_O[3:0] == 4'h0)
    else $error("floor write not taken");

  a_thread_select: assert property (
    !HANDLER_MODE_O && ctrl_wr && !EXC_ENTRY_I && !EXCEPTION_RETURN_CODE_I |=>
      USE_PSP_O == $past(SR_WDATA_I[cem_pkg::CTRL_ACTIVE_STACK_SELECT]))
    else $error("thread stack select not written");

  a_return_handler: assert property (
    EXCEPTION_RETURN_CODE_I && !EXC_ENTRY_I && !ctrl_wr &&
      !EXC_RET_CODE_I[cem_pkg::RET_THREAD_BIT] |=>
      HANDLER_MODE_O && !USE_PSP_O)
    else $error("return to handler mode wrong");

  a_ctrl_read_hnd: assert property (
    SR_RD_I && SR_SEL_I == cem_pkg::SEL_CTRL && HANDLER_MODE_O |=>
      !SR_RDATA_O[cem_pkg::CTRL_ACTIVE_STACK_SELECT])
    else $error("stack select read not zero in handler");

endmodule : cem_core_mask_ctrl

// >>> sim/cem_core_mask_ctrl_tb_top.sv
`timescale 1ns/1ps
module cem_core_mask_ctrl_tb_top;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic CLK_SYS_I, RESETN_I, SR_WR_I, SR_RD_I, CPS_I, CPS_SET_I, CPS_PRI_I;
  logic CPS_ESC_I, EXC_ENTRY_I, EXCEPTION_RETURN_CODE_I, EXC_RET_NMI_I, EXC_REQ_VALID_I;
  logic EXC_REQ_CFG_I, EXC_REQ_NMI_I, MR_SUSPEND_I, MR_RESUME_I, CB_LOAD_I;
  logic CB_ADVANCE_I, BR_WR_I, BR_BIT0_I, VEC_FETCH_I, VEC_BIT0_I;
  logic STK_RESTORE_I, EXEC_TRY_I;
  logic [2:0] SR_SEL_I;
  logic [31:0] SR_WDATA_I, STK_XS_I, SR_RDATA_O, XS_O;
  logic [3:0] EXC_RET_CODE_I, MR_NEXT_IDX_I, RESUME_IDX_O;
  logic [7:0] EXC_REQ_PRIO_I, CB_STATE_I, FLOOR_O;
  logic PRI_BLOCK_O, ESC_BLOCK_O, USE_PSP_O, UNPRIV_O, HANDLER_MODE_O;
  logic EXC_ALLOW_O, RESUME_VALID_O, CB_ACTIVE_O, T_FAULT_O;
  typedef struct {int sig; logic [31:0] val;} cem_note_t;
  cem_note_t exp_q[$];
  event chk_ev;
  int err_count, n_tests, cyc;
  logic [31:0] d;
  logic [3:0] idx;
  localparam int S_RD = 0, S_PRI = 1, S_ESC = 2, S_FLR = 3, S_PSP = 4;
  localparam int S_NPV = 5, S_HND = 6, S_ALW = 7, S_XS = 8, S_RV = 9;
  localparam int S_RI = 10, S_CB = 11, S_TF = 12, S_T = 13;

  cem_core_mask_ctrl dut (
    .CLK_SYS_I, .RESETN_I, .SR_WR_I, .SR_RD_I, .SR_SEL_I, .SR_WDATA_I,
    .CPS_I, .CPS_SET_I, .CPS_PRI_I, .CPS_ESC_I, .EXC_ENTRY_I, .EXCEPTION_RETURN_CODE_I,
    .EXC_RET_CODE_I, .EXC_RET_NMI_I, .EXC_REQ_VALID_I, .EXC_REQ_CFG_I,
    .EXC_REQ_NMI_I, .EXC_REQ_PRIO_I, .MR_SUSPEND_I, .MR_NEXT_IDX_I,
    .MR_RESUME_I, .CB_LOAD_I, .CB_STATE_I, .CB_ADVANCE_I, .BR_WR_I,
    .BR_BIT0_I, .VEC_FETCH_I, .VEC_BIT0_I, .STK_RESTORE_I, .STK_XS_I,
    .EXEC_TRY_I, .SR_RDATA_O, .PRI_BLOCK_O, .ESC_BLOCK_O, .FLOOR_O,
    .USE_PSP_O, .UNPRIV_O, .HANDLER_MODE_O, .EXC_ALLOW_O, .XS_O,
    .RESUME_VALID_O, .RESUME_IDX_O, .CB_ACTIVE_O, .T_FAULT_O
  );

  // ----------------------------------------------------------------
  // clock, timeout, result watcher
  // ----------------------------------------------------------------
  initial begin
    CLK_SYS_I = 1'b0;
    forever #2.5 CLK_SYS_I = ~CLK_SYS_I;
  end

  always @(posedge CLK_SYS_I) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      complete_run();
    end
  end

  function automatic logic [31:0] sel_out(input int s);
    case (s)
      S_RD: return SR_RDATA_O;
      S_PRI: return {31'h0, PRI_BLOCK_O};
      S_ESC: return {31'h0, ESC_BLOCK_O};
      S_FLR: return {24'h0, FLOOR_O};
      S_PSP: return {31'h0, USE_PSP_O};
      S_NPV: return {31'h0, UNPRIV_O};
      S_HND: return {31'h0, HANDLER_MODE_O};
      S_ALW: return {31'h0, EXC_ALLOW_O};
      S_XS: return XS_O;
      S_RV: return {31'h0, RESUME_VALID_O};
      S_RI: return {28'h0, RESUME_IDX_O};
      S_CB: return {31'h0, CB_ACTIVE_O};
      S_TF: return {31'h0, T_FAULT_O};
      default: return {31'h0, XS_O[cem_pkg::XS_T_BIT]};
    endcase
  endfunction : sel_out

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  initial begin
    cem_note_t e;
    forever begin
      @(chk_ev);
      while (exp_q.size() > 0) begin
        e = exp_q.pop_front();
        check(sel_out(e.sig), e.val);
      end
    end
  end

  // ----------------------------------------------------------------
  // driver tasks
  // ----------------------------------------------------------------
  task automatic step();
    @(posedge CLK_SYS_I);
    #1;
  endtask : step

  task automatic note(input int s, input logic [31:0] v);
    exp_q.push_back('{s, v});
    ->chk_ev;
  endtask : note

  task automatic sr_wr(input logic [2:0] s, input logic [31:0] v);
    SR_SEL_I = s;
    SR_WDATA_I = v;
    SR_WR_I = 1'b1;
    step();
    SR_WR_I = 1'b0;
    step();
  endtask : sr_wr

  task automatic sr_rd(input logic [2:0] s, input logic [31:0] v);
    SR_SEL_I = s;
    SR_RD_I = 1'b1;
    step();
    SR_RD_I = 1'b0;
    note(S_RD, v);
    step();
  endtask : sr_rd

  task automatic change_processor_state(input logic v, input logic p, input logic e);
    {CPS_SET_I, CPS_PRI_I, CPS_ESC_I, CPS_I} = {v, p, e, 1'b1};
    step();
    CPS_I = 1'b0;
    step();
  endtask : change_processor_state

  task automatic exc(input logic ent, input logic [3:0] c, input logic n);
    {EXC_RET_CODE_I, EXC_RET_NMI_I} = {c, n};
    {EXC_ENTRY_I, EXCEPTION_RETURN_CODE_I} = {ent, ~ent};
    step();
    {EXC_ENTRY_I, EXCEPTION_RETURN_CODE_I} = 2'b00;
    step();
  endtask : exc

  task automatic gate(input logic [15:0] m, input logic [7:0] pr);
    logic a;
    sr_wr(cem_pkg::SEL_PRI, {31'h0, m[0]});
    sr_wr(cem_pkg::SEL_ESC, {31'h0, m[1]});
    sr_wr(cem_pkg::SEL_FLOOR, {24'h0, m[7:4], 4'h0});
    {EXC_REQ_VALID_I, EXC_REQ_CFG_I, EXC_REQ_NMI_I} = m[14:12];
    EXC_REQ_PRIO_I = pr;
    step();
    EXC_REQ_VALID_I = 1'b0;
    a = m[14] && (m[12] || (!m[1] && (!m[13] || (!m[0] &&
        (m[7:4] == 4'h0 || pr < {m[7:4], 4'h0})))));
    note(S_ALW, {31'h0, a});
  endtask : gate

  task automatic tbit(input int src, input logic b);
    {BR_BIT0_I, VEC_BIT0_I, STK_XS_I} = {b, b, 7'h0, b, 24'h0};
    {BR_WR_I, STK_RESTORE_I, VEC_FETCH_I} = 3'b100 >> src;
    step();
    {BR_WR_I, STK_RESTORE_I, VEC_FETCH_I} = 3'b000;
    note(S_T, {31'h0, b});
    EXEC_TRY_I = 1'b1;
    step();
    EXEC_TRY_I = 1'b0;
    note(S_TF, {31'h0, ~b});
  endtask : tbit

  task automatic test_end(input string nm);
    step();
    $display("test %s done", nm);
  endtask : test_end

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {RESETN_I, SR_WR_I, SR_RD_I, CPS_I, CPS_SET_I, CPS_PRI_I} = '0;
    {CPS_ESC_I, EXC_ENTRY_I, EXCEPTION_RETURN_CODE_I, EXC_RET_NMI_I} = '0;
    {EXC_REQ_VALID_I, EXC_REQ_CFG_I, EXC_REQ_NMI_I, MR_SUSPEND_I} = '0;
    {MR_RESUME_I, CB_LOAD_I, CB_ADVANCE_I, BR_WR_I, BR_BIT0_I} = '0;
    {VEC_FETCH_I, VEC_BIT0_I, STK_RESTORE_I, EXEC_TRY_I} = '0;
    {SR_SEL_I, SR_WDATA_I, STK_XS_I, EXC_RET_CODE_I} = '0;
    {MR_NEXT_IDX_I, EXC_REQ_PRIO_I, CB_STATE_I} = '0;
    d = $urandom(32'hd8d1);
    repeat (12) @(posedge CLK_SYS_I);
    #1;
    RESETN_I = 1'b1;
    step();
    for (int i = 0; i < 5; i++) sr_rd(i[2:0], 32'h0000_0000);
    note(S_PSP, 32'h0000_0000);
    test_end("reset values");
    for (int k = 0; k < 6; k++) begin
      d = $urandom();
      sr_wr(cem_pkg::SEL_PRI, d);
      sr_rd(cem_pkg::SEL_PRI, {31'h0, d[0]});
      sr_wr(cem_pkg::SEL_ESC, d);
      sr_rd(cem_pkg::SEL_ESC, {31'h0, d[0]});
      sr_wr(cem_pkg::SEL_FLOOR, d);
      note(S_FLR, {24'h0, d[7:4], 4'h0});
      sr_rd(cem_pkg::SEL_FLOOR, {24'h0, d[7:4], 4'h0});
      sr_wr(cem_pkg::SEL_CTRL, d);
      note(S_PSP, {31'h0, d[1]});
      note(S_NPV, {31'h0, d[0]});
      sr_rd(cem_pkg::SEL_CTRL, {30'h0, d[1:0]});
      sr_rd(3'h4 + k[1:0], 32'h0000_0000);
    end
    for (int k = 0; k < 4; k++) begin
      change_processor_state(k[0], ~k[1], k[1]);
      note(k[1] ? S_ESC : S_PRI, {31'h0, k[0]});
    end
    test_end("register access");
    gate(16'h6040, 8'h40);
    gate(16'h6040, 8'h3f);
    gate(16'h5002, 8'h00);
    gate(16'h4002, 8'h00);
    for (int k = 0; k < 40; k++) begin
      d = $urandom();
      gate({1'b0, d[14] | d[15], d[12], d[13] & ~d[12], 4'h0,
            d[11:10] == 2'b00 ? 4'h0 : d[7:4], 2'b00, d[1] & d[2], d[0]},
           d[23:16]);
    end
    test_end("exception gate");
    sr_wr(cem_pkg::SEL_CTRL, 32'h0000_0002);
    note(S_PSP, 32'h0000_0001);
    exc(1'b1, 4'h0, 1'b0);
    note(S_HND, 32'h0000_0001);
    note(S_PSP, 32'h0000_0000);
    sr_wr(cem_pkg::SEL_CTRL, 32'h0000_0003);
    note(S_PSP, 32'h0000_0000);
    note(S_NPV, 32'h0000_0001);
    sr_rd(cem_pkg::SEL_CTRL, 32'h0000_0001);
    change_processor_state(1'b1, 1'b0, 1'b1);
    exc(1'b0, 4'h1, 1'b1);
    note(S_HND, 32'h0000_0001);
    note(S_ESC, 32'h0000_0001);
    exc(1'b0, 4'hd, 1'b0);
    note(S_HND, 32'h0000_0000);
    note(S_PSP, 32'h0000_0001);
    note(S_ESC, 32'h0000_0000);
    exc(1'b1, 4'h0, 1'b0);
    exc(1'b0, 4'h9, 1'b0);
    note(S_PSP, 32'h0000_0000);
    test_end("entry and return");
    tbit(2, 1'b1);
    MR_RESUME_I = 1'b1;
    step();
    MR_RESUME_I = 1'b0;
    note(S_RV, 32'h0000_0000);
    idx = 4'($urandom_range(15, 1));
    MR_NEXT_IDX_I = idx;
    MR_SUSPEND_I = 1'b1;
    step();
    MR_SUSPEND_I = 1'b0;
    note(S_XS, 32'h0100_0000 | {16'h0, idx, 12'h0});
    MR_RESUME_I = 1'b1;
    step();
    MR_RESUME_I = 1'b0;
    note(S_RV, 32'h0000_0001);
    note(S_RI, {28'h0, idx});
    for (int s = 0; s < 3; s++) begin
      tbit(s, 1'b0);
      tbit(2, 1'b1);
    end
    test_end("execution state");
    for (int n = 0; n < 2; n++) begin
      CB_STATE_I = n ? 8'h08 : 8'h01;
      CB_LOAD_I = 1'b1;
      step();
      CB_LOAD_I = 1'b0;
      note(S_CB, 32'h0000_0001);
      CB_ADVANCE_I = 1'b1;
      for (int i = 0; i < (n ? 1 : 4); i++) begin
        step();
        note(S_CB, {31'h0, (n == 0 && i < 3)});
      end
      CB_ADVANCE_I = 1'b0;
    end
    test_end("conditional block");
    complete_run();
  end
endmodule : cem_core_mask_ctrl_tb_top
